/* iowd_defs.vh */
// register indexes, reset values and field layout for the i/o window decode block
`ifndef IOWD_DEFS_VH
`define IOWD_DEFS_VH
`define IOWD_IDX_W0_START_LOW 8'h08
`define IOWD_IDX_W0_START_HIGH 8'h09
`define IOWD_IDX_W0_END_LOW 8'h0A
`define IOWD_IDX_W0_END_HIGH 8'h0B
`define IOWD_IDX_W1_START_LOW 8'h0C
`define IOWD_IDX_W1_START_HIGH 8'h0D
`define IOWD_IDX_W1_END_LOW 8'h0E
`define IOWD_IDX_W1_END_HIGH 8'h0F
`define IOWD_IDX_W0_OFFSET_LOW 8'h36
`define IOWD_IDX_W0_OFFSET_HIGH 8'h37
`define IOWD_IDX_W1_OFFSET_LOW 8'h38
`define IOWD_IDX_W1_OFFSET_HIGH 8'h39
`define IOWD_IDX_MAP_ENABLE 8'h06
`define IOWD_REG_RESET 8'h00
`define IOWD_EN_BIT_W0 6
`define IOWD_EN_BIT_W1 7
`define IOWD_UNMAPPED_READ 32'h00000000
`endif

/* iowd_host_model.sv */
// host master model, one i/o cycle per call
`timescale 1ns/1ps
`default_nettype none
module iowd_host_model(
	input wire logic clock_i,
	output logic [15:0] io_addr_o = 16'h0,
	output logic io_valid_o = 1'b0
);
	task automatic issue(logic [15:0] a);
		@(posedge clock_i);
		{io_addr_o, io_valid_o} <= {a, 1'b1};
		@(posedge clock_i);
		// flipped so a stale address never decodes by luck
		{io_addr_o, io_valid_o} <= {~a, 1'b0};
	endtask
endmodule
`default_nettype wire

/* iowd_io_window_decode.v */
// register bank of two i/o windows with avalon-mm slave and decode
`timescale 1ns/1ps
`default_nettype none
`include "iowd_defs.vh"
module iowd_io_window_decode #(
	parameter AW = 16
) (
	input wire clock_i,
	input wire sys_rst_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire [AW-1:0] io_addr_i,
	input wire io_valid_i,
	output reg io_hit_o,
	output reg io_window_o,
	output reg [AW-1:0] card_addr_o
);
	// per window byte registers, index 0 is window 0
	reg [7:0] start_low [0:1];
	reg [7:0] start_high [0:1];
	reg [7:0] end_low [0:1];
	reg [7:0] end_high [0:1];
	reg [7:0] offset_low [0:1];
	reg [7:0] offset_high [0:1];
	reg [7:0] map_enable;
	reg bus_state;
	reg next_bus_state;
	reg [7:0] next_rdata;
	reg next_mapped;
	reg [31:0] next_readdata;
	reg next_io_hit;
	reg next_io_window;
	reg [AW-1:0] next_card_addr;

	wire bus_request;
	wire resp_pending;
	wire rd_accept;
	wire wr_accept;
	wire wr_lane0;
	wire wr_map_enable;
	wire [1:0] hit;
	wire [AW-1:0] card_addr [0:1];
	wire [1:0] win_rd_sel;
	wire [7:0] win_rd_val [0:1];

	// the slave only needs to know whether it owes an answer
	localparam BUS_IDLE = 1'b0;
	localparam BUS_ACK = 1'b1;

	assign bus_request = avs_read_i || avs_write_i;
	assign resp_pending = (bus_state == BUS_ACK);
	// one wait state on every access so read data can be registered
	assign avs_waitrequest_o = bus_request && !resp_pending;
	// read data captured in the wait cycle, stands at the accepting edge
	assign rd_accept = avs_read_i && !resp_pending;
	// writes land only at the edge that sees waitrequest low
	assign wr_accept = avs_write_i && resp_pending;
	assign wr_lane0 = wr_accept && avs_byteenable_i[0];
	assign wr_map_enable = wr_lane0 && (avs_address_i == `IOWD_IDX_MAP_ENABLE);

	always @* begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (bus_request) begin
					next_bus_state = BUS_ACK;
				end
			end
			BUS_ACK: begin
				// back to back requests still get their own wait state
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	// window registers answer from their own loop
	always @* begin
		next_rdata = 8'h00;
		next_mapped = 1'b1;
		if (avs_address_i == `IOWD_IDX_MAP_ENABLE) begin
			next_rdata = map_enable;
		end else if (win_rd_sel[0]) begin
			next_rdata = win_rd_val[0];
		end else if (win_rd_sel[1]) begin
			next_rdata = win_rd_val[1];
		end else begin
			next_mapped = 1'b0;
		end
	end

	always @* begin
		if (next_mapped) begin
			next_readdata = {24'h000000, next_rdata};
		end else begin
			// unmapped indexes read as zero rather than raising an error
			next_readdata = `IOWD_UNMAPPED_READ;
		end
	end

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			bus_state <= BUS_IDLE;
			avs_readdata_o <= 32'h00000000;
		end else begin
			bus_state <= next_bus_state;
			if (rd_accept) begin
				avs_readdata_o <= next_readdata;
			end
		end
	end

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			map_enable <= `IOWD_REG_RESET;
		end else if (wr_map_enable) begin
			map_enable <= avs_writedata_i[7:0];
		end
	end

	genvar w;
	generate
		for (w = 0; w < 2; w = w + 1) begin : g_win
			// window 1 indexes sit four above window 0, offsets two above
			localparam [31:0] SL_FULL = `IOWD_IDX_W0_START_LOW + 32'h00000004 * w;
			localparam [31:0] SH_FULL = `IOWD_IDX_W0_START_HIGH + 32'h00000004 * w;
			localparam [31:0] EL_FULL = `IOWD_IDX_W0_END_LOW + 32'h00000004 * w;
			localparam [31:0] EH_FULL = `IOWD_IDX_W0_END_HIGH + 32'h00000004 * w;
			localparam [31:0] OL_FULL = `IOWD_IDX_W0_OFFSET_LOW + 32'h00000002 * w;
			localparam [31:0] OH_FULL = `IOWD_IDX_W0_OFFSET_HIGH + 32'h00000002 * w;
			// indexes are one byte wide, upper bits always zero
			localparam [7:0] SL = SL_FULL[7:0];
			localparam [7:0] SH = SH_FULL[7:0];
			localparam [7:0] EL = EL_FULL[7:0];
			localparam [7:0] EH = EH_FULL[7:0];
			localparam [7:0] OL = OL_FULL[7:0];
			localparam [7:0] OH = OH_FULL[7:0];
			reg [7:0] rd_val;
			reg rd_sel;
			wire wr_start_low;
			wire wr_start_high;
			wire wr_end_low;
			wire wr_end_high;
			wire wr_offset_low;
			wire wr_offset_high;
			wire [AW-1:0] start_addr;
			wire [AW-1:0] end_addr;
			wire [AW-1:0] offset_addr;

			assign wr_start_low = wr_lane0 && (avs_address_i == SL);
			assign wr_start_high = wr_lane0 && (avs_address_i == SH);
			assign wr_end_low = wr_lane0 && (avs_address_i == EL);
			assign wr_end_high = wr_lane0 && (avs_address_i == EH);
			assign wr_offset_low = wr_lane0 && (avs_address_i == OL);
			assign wr_offset_high = wr_lane0 && (avs_address_i == OH);
			// bounds follow the live registers, no shadow copy
			assign start_addr = {start_high[w], start_low[w]};
			assign end_addr = {end_high[w], end_low[w]};
			assign offset_addr = {offset_high[w], offset_low[w]};

			always @* begin
				rd_val = 8'h00;
				rd_sel = 1'b1;
				case (avs_address_i)
					SL: rd_val = start_low[w];
					SH: rd_val = start_high[w];
					EL: rd_val = end_low[w];
					EH: rd_val = end_high[w];
					OL: rd_val = offset_low[w];
					OH: rd_val = offset_high[w];
					default: rd_sel = 1'b0;
				endcase
			end
			assign win_rd_sel[w] = rd_sel;
			assign win_rd_val[w] = rd_val;

			always @(posedge clock_i) begin
				if (sys_rst_i) begin
					start_low[w] <= `IOWD_REG_RESET;
					start_high[w] <= `IOWD_REG_RESET;
				end else begin
					if (wr_start_low) begin
						start_low[w] <= avs_writedata_i[7:0];
					end
					if (wr_start_high) begin
						start_high[w] <= avs_writedata_i[7:0];
					end
				end
			end

			always @(posedge clock_i) begin
				if (sys_rst_i) begin
					end_low[w] <= `IOWD_REG_RESET;
					end_high[w] <= `IOWD_REG_RESET;
				end else begin
					if (wr_end_low) begin
						end_low[w] <= avs_writedata_i[7:0];
					end
					if (wr_end_high) begin
						end_high[w] <= avs_writedata_i[7:0];
					end
				end
			end

			always @(posedge clock_i) begin
				if (sys_rst_i) begin
					offset_low[w] <= `IOWD_REG_RESET;
					offset_high[w] <= `IOWD_REG_RESET;
				end else begin
					if (wr_offset_low) begin
						// offset bit 0 must stay zero, so it is not storable
						offset_low[w] <= {avs_writedata_i[7:1], 1'b0};
					end
					if (wr_offset_high) begin
						offset_high[w] <= avs_writedata_i[7:0];
					end
				end
			end

			iowd_window_match #(
				.AW(AW)
			) u_match (
				.host_addr_i(io_addr_i),
				.start_i(start_addr),
				.end_i(end_addr),
				.offset_i(offset_addr),
				.enable_i(map_enable[`IOWD_EN_BIT_W0 + w]),
				.hit_o(hit[w]),
				.card_addr_o(card_addr[w])
			);
		end
	endgenerate

	// window 0 wins if software lets the two overlap
	always @* begin
		next_io_hit = io_valid_i && (hit[0] || hit[1]);
		// idle cycles report no window, so window 1 never shows without a hit
		next_io_window = io_valid_i && !hit[0] && hit[1];
		if (hit[0]) begin
			next_card_addr = card_addr[0];
		end else begin
			next_card_addr = card_addr[1];
		end
	end

	always @(posedge clock_i) begin
		if (sys_rst_i) begin
			io_hit_o <= 1'b0;
			io_window_o <= 1'b0;
			card_addr_o <= {AW{1'b0}};
		end else begin
			io_hit_o <= next_io_hit;
			io_window_o <= next_io_window;
			card_addr_o <= next_card_addr;
		end
	end
endmodule
`default_nettype wire

/* iowd_props.sv */
// assertions on the i/o window decode ports
`timescale 1ns/1ps
`default_nettype none
module iowd_props(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic io_valid_i,
	input wire logic io_hit_o,
	input wire logic io_window_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_rw; $rose(avs_read_i) |-> avs_waitrequest_o; endproperty
	a_rw: assert property (p_rw) else $error("no read wait");
	property p_ww; $rose(avs_write_i) |-> avs_waitrequest_o; endproperty
	a_ww: assert property (p_ww) else $error("no write wait");
	property p_one; avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
	a_one: assert property (p_one) else $error("long wait");
	property p_idle; !avs_read_i && !avs_write_i |-> !avs_waitrequest_o; endproperty
	a_idle: assert property (p_idle) else $error("idle wait");
	property p_hv; io_hit_o |-> $past(io_valid_i); endproperty
	a_hv: assert property (p_hv) else $error("stray hit");
	property p_nv; !io_valid_i |=> !io_hit_o; endproperty
	a_nv: assert property (p_nv) else $error("idle hit");
	property p_win; io_window_o |-> io_hit_o; endproperty
	a_win: assert property (p_win) else $error("window no hit");
	property p_rst; $fell(sys_rst_i) |-> !io_hit_o && !io_window_o; endproperty
	a_rst: assert property (p_rst) else $error("reset hit");
endmodule
bind iowd_io_window_decode iowd_props u_props(.*);
`default_nettype wire

/* iowd_window_match.v */
// one i/o window: inclusive range compare and card address translation
`timescale 1ns/1ps
`default_nettype none
module iowd_window_match #(
	parameter AW = 16
) (
	input wire [AW-1:0] host_addr_i,
	input wire [AW-1:0] start_i,
	input wire [AW-1:0] end_i,
	input wire [AW-1:0] offset_i,
	input wire enable_i,
	output wire hit_o,
	output wire [AW-1:0] card_addr_o
);
	// both bounds inclusive, full width compare
	assign hit_o = enable_i && (host_addr_i >= start_i) && (host_addr_i <= end_i);
	// wraps modulo the address width like the card bus does
	assign card_addr_o = host_addr_i + offset_i;
endmodule
`default_nettype wire

/* test_io_window_address_decode.sv */
// bench for the i/o window decode block
`timescale 1ns/1ps
`default_nettype none
module test_io_window_address_decode;
	logic clock_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic avs_waitrequest_o, io_valid_i, io_hit_o, io_window_o;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [7:0] avs_address_i = 8'h0;
	logic [15:0] io_addr_i, card_addr_o;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	int err_total, comparisons;
	logic [31:0] rd_q;
	iowd_io_window_decode dut(.*);
	iowd_host_model host(.clock_i(clock_i), .io_addr_o(io_addr_i), .io_valid_o(io_valid_i));
	initial forever #50 clock_i = ~clock_i;
	task automatic give_verdict;
		$display("%0d checks, %0d mismatches", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(logic r, int a, d);
		int n = 0;
		@(posedge clock_i);
		avs_address_i <= 8'(a);
		avs_writedata_i <= d;
		avs_read_i <= r;
		avs_write_i <= !r;
		// waitrequest and read data are taken at the same rising edge
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0 && ++n < 20);
		rd_q = avs_readdata_o;
		if (n >= 20) begin
			err_total++;
			give_verdict();
		end
		{avs_read_i, avs_write_i} <= 2'b00;
	endtask
	task automatic t_regs;
		for (int i = 0; i < 12; i++) begin
			int a = i < 8 ? 8 + i : 46 + i;
			bus(1'b1, a, 0);
			chk("reset", 0, rd_q);
			bus(1'b0, a, 160 + 2 * i);
		end
		// all written before readback, so aliased indexes show up
		for (int i = 0; i < 12; i++) begin
			bus(1'b1, i < 8 ? 8 + i : 46 + i, 0);
			chk("reg", 160 + 2 * i, rd_q);
		end
		bus(1'b0, 8'h36, 8'hB1);
		bus(1'b1, 8'h36, 0);
		chk("offset bit0", 8'hB0, rd_q);
		$display("regs done");
	endtask
	task automatic probe(logic [15:0] a, logic [1:0] hw);
		logic [17:0] e;
		// without a window 0 hit the card address follows window 1
		e = {hw, 16'(a + (hw == 2'b10 ? 16'hB2B0 : 16'hB6B4))};
		host.issue(a);
		#1;
		chk("io", e, {io_hit_o, io_window_o, card_addr_o});
	endtask
	task automatic t_dec;
		probe(16'hA2A0, 2'b00);
		bus(1'b0, 6, 8'hC0);
		probe(16'hA29F, 2'b00);
		probe(16'hA2A0, 2'b10);
		probe(16'hA6A4, 2'b10);
		probe(16'hA6A5, 2'b00);
		probe(16'hAAA8, 2'b11);
		bus(1'b0, 6, 8'h80);
		probe(16'hAEAC, 2'b11);
		probe(16'hA2A0, 2'b00);
		$display("decode done");
	endtask
	task automatic t_reset;
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		bus(1'b1, 8'h0D, 0);
		chk("reset start high", 0, rd_q);
		bus(1'b1, 8'h06, 0);
		chk("reset enable", 0, rd_q);
		$display("reset done");
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_dec();
		t_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
